// ---- hdl/sre_pkg.sv ----
package sre_pkg;
   // Array geometry
   localparam int ADDR_W    = 11;
   localparam int DATA_W    = 8;
   localparam int MEM_DEPTH = 2048;
   localparam int BANK_W    = 3;
   localparam int CNT_W     = 8;

   // Device type field; value is arbitrary
   localparam logic [3:0] SEL_TYPE = 4'h5;

   // Bit positions within a byte frame
   localparam logic [3:0] LAST_DATA_BIT = 4'h7;
   localparam logic [3:0] ACK_SLOT      = 4'h8;
   localparam logic [2:0] RX_LAST       = 3'h7;

   // Link timing: serial clock period and master clock period
   localparam int SCL_PERIOD_NS  = 10000;
   localparam int MCLK_PERIOD_NS = 8;
   localparam int QTR_CYC =
      (SCL_PERIOD_NS / 4 + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
   localparam int DIV_W = 16;

   // Read sequence steps of the master
   typedef enum logic [1:0] {
      SQ_DEVW,
      SQ_WORD,
      SQ_DEVR,
      SQ_DATA
   } sre_seq_e;
endpackage

// ---- hdl/sre_link_if.sv ----
`timescale 1ns/1ps
`default_nettype none
interface sre_link_if;
   logic scl_o;
   logic scl_oe_n;
   logic sda_m_o;
   logic sda_m_oe_n;
   logic sda_d_o;
   logic sda_d_oe_n;
   logic scl;
   logic sda;

   // Pulled-up lines; scl has the master driver only, sda is the wired-AND of both open-drain drivers
   assign scl = scl_oe_n | scl_o;
   assign sda = (sda_m_oe_n | sda_m_o) & (sda_d_oe_n | sda_d_o);

   modport master (
      output scl_o,
      output scl_oe_n,
      output sda_m_o,
      output sda_m_oe_n,
      input  scl,
      input  sda
   );

   modport device (
      output sda_d_o,
      output sda_d_oe_n,
      input  scl,
      input  sda
   );
endinterface
`default_nettype wire

// ---- hdl/sre_device.sv ----
// Functional notes
// - Master sets address by dummy write first
// - Dummy write: start, write address, word address
// - Repeated start then read address after ack
// - Acknowledge read address, send byte at counter
// - Master ends read with nack then stop
// - Sequential read starts as current or random
// - Each master acknowledge requests one more byte
// - Read counter increments over all address bits
// - Counter wraps from 2047 to zero
// - Bank bits form upper address bits
// - Counter holds last accessed address plus one
// - Ninth clock matters: nack or stop there
// - Stop is data rising with clock high
`timescale 1ns/1ps
`default_nettype none
module sre_device import sre_pkg::*; (
   input  wire logic              mclk_i,
   input  wire logic              srst_i,
   input  wire logic              ce_i,
   input  wire logic              load_en_i,
   input  wire logic [ADDR_W-1:0] load_addr_i,
   input  wire logic [DATA_W-1:0] load_data_i,
   output logic                   byte_sent_o,
   sre_link_if.device             link
);
   typedef enum logic [2:0] {
      D_IDLE,
      D_RX,
      D_ACK,
      D_TX,
      D_MACK
   } sre_dev_e;

   logic [DATA_W-1:0] mem_r [MEM_DEPTH];

   sre_dev_e          st_r,   st_nxt;
   logic [DATA_W-1:0] sh_r,   sh_nxt;
   logic [2:0]        cnt_r,  cnt_nxt;
   logic [ADDR_W-1:0] addr_r, addr_nxt;
   logic [BANK_W-1:0] bank_r, bank_nxt;
   logic              word_r, word_nxt;
   logic              rd_r,   rd_nxt;
   logic              rel_r,  rel_nxt;
   logic              tgl_r,  tgl_nxt;
   logic              sda_pos_r;
   logic              start_c;
   logic              stop_c;
   logic              load_c;
   logic [DATA_W-1:0] rx_byte;

   logic tgl_meta_r;
   logic tgl_s_r;
   logic tgl_d_r;
   logic sent_r;

   // Backing store, filled from the system side
   always_ff @(posedge mclk_i) begin
      if (ce_i && load_en_i) begin
         mem_r[load_addr_i] <= load_data_i;
      end
   end

   // Data sampled while the clock is high; srst_i releases only while
   // the link clock stands still, so the async reset is safe here
   always_ff @(posedge link.scl or posedge srst_i) begin
      if (srst_i) begin
         sda_pos_r <= 1'b1;
      end else begin
         sda_pos_r <= link.sda;
      end
   end

   // A level that moved between rising and falling edge is a condition
   assign start_c = sda_pos_r & ~link.sda;
   assign stop_c  = ~sda_pos_r & link.sda;
   assign rx_byte = {sh_r[DATA_W-2:0], sda_pos_r};

   // Next state, evaluated at each falling clock edge
   always_comb begin
      st_nxt   = st_r;
      sh_nxt   = sh_r;
      cnt_nxt  = cnt_r;
      addr_nxt = addr_r;
      bank_nxt = bank_r;
      word_nxt = word_r;
      rd_nxt   = rd_r;
      rel_nxt  = rel_r;
      tgl_nxt  = tgl_r;
      load_c   = 1'b0;
      if (start_c) begin
         st_nxt   = D_RX;
         cnt_nxt  = 3'h0;
         word_nxt = 1'b0;
         rel_nxt  = 1'b1;
      end else if (stop_c) begin
         st_nxt  = D_IDLE;
         rel_nxt = 1'b1;
      end else begin
         case (st_r)
            D_RX: begin
               sh_nxt  = rx_byte;
               cnt_nxt = cnt_r + 3'h1;
               if (cnt_r == RX_LAST) begin
                  if (word_r) begin
                     addr_nxt = {bank_r, rx_byte};
                     st_nxt   = D_ACK;
                     rel_nxt  = 1'b0;
                  end else if (rx_byte[7:4] == SEL_TYPE) begin
                     bank_nxt = rx_byte[3:1];
                     rd_nxt   = rx_byte[0];
                     st_nxt   = D_ACK;
                     rel_nxt  = 1'b0;
                  end else begin
                     st_nxt = D_IDLE;
                  end
               end
            end
            D_ACK: begin
               rel_nxt = 1'b1;
               cnt_nxt = 3'h0;
               if (rd_r && !word_r) begin
                  load_c = 1'b1;
               end else if (!word_r) begin
                  word_nxt = 1'b1;
                  st_nxt   = D_RX;
               end else begin
                  // Address set; wait for the repeated start
                  st_nxt = D_IDLE;
               end
            end
            D_TX: begin
               cnt_nxt = cnt_r + 3'h1;
               sh_nxt  = {sh_r[DATA_W-2:0], 1'b0};
               if (cnt_r == RX_LAST) begin
                  rel_nxt = 1'b1;
                  st_nxt  = D_MACK;
               end else begin
                  rel_nxt = sh_r[DATA_W-2];
               end
            end
            D_MACK: begin
               cnt_nxt = 3'h0;
               if (!sda_pos_r) begin
                  load_c = 1'b1;
               end else begin
                  st_nxt = D_IDLE;
               end
            end
            D_IDLE: begin
               rel_nxt = 1'b1;
            end
            default: begin
               st_nxt  = D_IDLE;
               rel_nxt = 1'b1;
            end
         endcase
      end
      // Fetch at the counter, then step it; the 11-bit add wraps to 0
      if (load_c) begin
         sh_nxt   = mem_r[addr_r];
         rel_nxt  = mem_r[addr_r][DATA_W-1];
         addr_nxt = addr_r + 11'h001;
         tgl_nxt  = ~tgl_r;
         st_nxt   = D_TX;
      end
   end

   // Falling edge keeps every data change inside the clock low phase
   always_ff @(negedge link.scl or posedge srst_i) begin
      if (srst_i) begin
         st_r   <= D_IDLE;
         sh_r   <= 8'h00;
         cnt_r  <= 3'h0;
         addr_r <= 11'h000;
         bank_r <= 3'h0;
         word_r <= 1'b0;
         rd_r   <= 1'b0;
         rel_r  <= 1'b1;
         tgl_r  <= 1'b0;
      end else begin
         st_r   <= st_nxt;
         sh_r   <= sh_nxt;
         cnt_r  <= cnt_nxt;
         addr_r <= addr_nxt;
         bank_r <= bank_nxt;
         word_r <= word_nxt;
         rd_r   <= rd_nxt;
         rel_r  <= rel_nxt;
         tgl_r  <= tgl_nxt;
      end
   end

   assign link.sda_d_o    = 1'b0;
   assign link.sda_d_oe_n = rel_r;

   // Byte event crosses to the system clock as a toggle
   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         tgl_meta_r <= 1'b0;
         tgl_s_r    <= 1'b0;
         tgl_d_r    <= 1'b0;
         sent_r     <= 1'b0;
      end else if (ce_i) begin
         tgl_meta_r <= tgl_r;
         tgl_s_r    <= tgl_meta_r;
         tgl_d_r    <= tgl_s_r;
         sent_r     <= tgl_s_r ^ tgl_d_r;
      end
   end

   assign byte_sent_o = sent_r;
endmodule
`default_nettype wire

// ---- hdl/sre_master.sv ----
`timescale 1ns/1ps
`default_nettype none
module sre_master import sre_pkg::*; #(
   parameter int QTR_CYC_P = QTR_CYC
) (
   input  wire logic              mclk_i,
   input  wire logic              srst_i,
   input  wire logic              ce_i,
   input  wire logic              cmd_valid_i,
   output logic                   cmd_ready_o,
   input  wire logic              cmd_random_i,
   input  wire logic [ADDR_W-1:0] cmd_addr_i,
   input  wire logic [CNT_W-1:0]  cmd_count_i,
   output logic [DATA_W-1:0]      rdata_o,
   output logic                   rvalid_o,
   output logic                   done_o,
   output logic                   nack_o,
   sre_link_if.master             link
);
   typedef enum logic [1:0] {
      M_IDLE,
      M_START,
      M_BYTE,
      M_STOP
   } sre_mst_e;

   localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(QTR_CYC_P - 1);

   sre_mst_e          st_r,    st_nxt;
   sre_seq_e          seq_r,   seq_nxt;
   logic [1:0]        q_r,     q_nxt;
   logic [DIV_W-1:0]  div_r,   div_nxt;
   logic [3:0]        bit_r,   bit_nxt;
   logic [DATA_W-1:0] sh_r,    sh_nxt;
   logic              ack_r,   ack_nxt;
   logic [CNT_W-1:0]  left_r,  left_nxt;
   logic [ADDR_W-1:0] word_r,  word_nxt;
   logic              scl_r,   scl_nxt;
   logic              sda_r,   sda_nxt;
   logic [DATA_W-1:0] rdata_r, rdata_nxt;
   logic              rv_r,    rv_nxt;
   logic              done_r,  done_nxt;
   logic              nack_r,  nack_nxt;
   logic              sda_meta_r;
   logic              sda_s_r;
   logic              last_c;

   // Bus data comes from another domain; two flops before use
   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         sda_meta_r <= 1'b1;
         sda_s_r    <= 1'b1;
      end else if (ce_i) begin
         sda_meta_r <= link.sda;
         sda_s_r    <= sda_meta_r;
      end
   end

   assign last_c = (left_r <= 8'h01);

   // Each bit is four quarters: data set, clock up, sample, clock down
   always_comb begin
      st_nxt    = st_r;
      seq_nxt   = seq_r;
      q_nxt     = q_r;
      div_nxt   = div_r;
      bit_nxt   = bit_r;
      sh_nxt    = sh_r;
      ack_nxt   = ack_r;
      left_nxt  = left_r;
      word_nxt  = word_r;
      scl_nxt   = scl_r;
      sda_nxt   = sda_r;
      rdata_nxt = rdata_r;
      rv_nxt    = 1'b0;
      done_nxt  = 1'b0;
      nack_nxt  = nack_r;
      if (st_r == M_IDLE) begin
         if (cmd_valid_i) begin
            st_nxt   = M_START;
            q_nxt    = 2'h0;
            div_nxt  = 16'h0000;
            nack_nxt = 1'b0;
            left_nxt = cmd_count_i;
            word_nxt = cmd_addr_i;
            seq_nxt  = cmd_random_i ? SQ_DEVW : SQ_DEVR;
         end
      end else if (div_r != DIV_LAST) begin
         div_nxt = div_r + 16'h0001;
      end else begin
         div_nxt = 16'h0000;
         q_nxt   = q_r + 2'h1;
         case (q_r)
            2'h0: begin
               if (st_r == M_START) begin
                  // Clock drops first so the device sees a clean edge
                  scl_nxt = 1'b0;
                  sda_nxt = 1'b1;
               end else if (st_r == M_STOP) begin
                  sda_nxt = 1'b0;
               end else if (bit_r == ACK_SLOT) begin
                  sda_nxt = (seq_r == SQ_DATA) ? last_c : 1'b1;
               end else begin
                  sda_nxt = (seq_r == SQ_DATA) ? 1'b1 : sh_r[DATA_W-1];
               end
            end
            2'h1: begin
               scl_nxt = 1'b1;
            end
            2'h2: begin
               if (st_r == M_START) begin
                  sda_nxt = 1'b0;
               end else if (st_r == M_STOP) begin
                  sda_nxt = 1'b1;
               end else if (bit_r == ACK_SLOT) begin
                  ack_nxt = sda_s_r;
               end else begin
                  sh_nxt = {sh_r[DATA_W-2:0], sda_s_r};
               end
            end
            default: begin
               if (st_r == M_START) begin
                  scl_nxt = 1'b0;
                  st_nxt  = M_BYTE;
                  bit_nxt = 4'h0;
                  sh_nxt  = {SEL_TYPE, word_r[10:8],
                             seq_r == SQ_DEVR};
               end else if (st_r == M_STOP) begin
                  st_nxt   = M_IDLE;
                  done_nxt = 1'b1;
               end else begin
                  scl_nxt = 1'b0;
                  bit_nxt = bit_r + 4'h1;
                  if (bit_r == ACK_SLOT) begin
                     bit_nxt = 4'h0;
                     if (seq_r == SQ_DATA) begin
                        rdata_nxt = sh_r;
                        rv_nxt    = 1'b1;
                        left_nxt  = left_r - 8'h01;
                        if (last_c) begin
                           st_nxt = M_STOP;
                        end
                     end else if (ack_r) begin
                        nack_nxt = 1'b1;
                        st_nxt   = M_STOP;
                     end else if (seq_r == SQ_DEVW) begin
                        seq_nxt = SQ_WORD;
                        sh_nxt  = word_r[DATA_W-1:0];
                     end else if (seq_r == SQ_WORD) begin
                        seq_nxt = SQ_DEVR;
                        st_nxt  = M_START;
                     end else begin
                        seq_nxt = SQ_DATA;
                     end
                  end
               end
            end
         endcase
      end
   end

   // State registers; clock enable freezes everything
   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         st_r    <= M_IDLE;
         seq_r   <= SQ_DEVR;
         q_r     <= 2'h0;
         div_r   <= 16'h0000;
         bit_r   <= 4'h0;
         sh_r    <= 8'h00;
         ack_r   <= 1'b1;
         left_r  <= 8'h00;
         word_r  <= 11'h000;
         scl_r   <= 1'b1;
         sda_r   <= 1'b1;
         rdata_r <= 8'h00;
         rv_r    <= 1'b0;
         done_r  <= 1'b0;
         nack_r  <= 1'b0;
      end else if (ce_i) begin
         st_r    <= st_nxt;
         seq_r   <= seq_nxt;
         q_r     <= q_nxt;
         div_r   <= div_nxt;
         bit_r   <= bit_nxt;
         sh_r    <= sh_nxt;
         ack_r   <= ack_nxt;
         left_r  <= left_nxt;
         word_r  <= word_nxt;
         scl_r   <= scl_nxt;
         sda_r   <= sda_nxt;
         rdata_r <= rdata_nxt;
         rv_r    <= rv_nxt;
         done_r  <= done_nxt;
         nack_r  <= nack_nxt;
      end
   end

   // Open drain: only ever pulls low, released means high
   assign link.scl_o      = 1'b0;
   assign link.scl_oe_n   = scl_r;
   assign link.sda_m_o    = 1'b0;
   assign link.sda_m_oe_n = sda_r;
   assign cmd_ready_o     = ce_i && (st_r == M_IDLE);
   assign rdata_o         = rdata_r;
   assign rvalid_o        = rv_r;
   assign done_o          = done_r;
   assign nack_o          = nack_r;
endmodule
`default_nettype wire

// ---- tb/sre_link_monitor.sv ----
`timescale 1ns/1ps
`default_nettype none
module sre_link_monitor import sre_pkg::*; (
   input wire logic mclk_i,
   input wire logic srst_i,
   input wire logic scl,
   input wire logic sda,
   input wire logic sda_d_o,
   input wire logic sda_d_oe_n,
   input wire logic sda_m_oe_n
);
   logic       scl_r;
   logic       sda_r;
   logic       first_r;
   logic       dtx_r;
   logic [3:0] idx_r;
   logic [7:0] sh_r;
   logic       start_w;
   logic       stop_w;

   // Line conditions, judged one mclk apart
   assign start_w = scl & scl_r & sda_r & ~sda;
   assign stop_w  = scl & scl_r & ~sda_r & sda;

   // Frame tracker; a repeated start counts a stray rise, then resets it
   always_ff @(posedge mclk_i) begin
      scl_r <= scl;
      sda_r <= sda;
      if (srst_i || start_w) begin
         idx_r   <= 4'h0;
         first_r <= 1'h1;
         dtx_r   <= 1'h0;
      end else if (scl && !scl_r) begin
         idx_r <= (idx_r == 4'h9) ? 4'h1 : idx_r + 4'h1;
         if (idx_r != 4'h8) sh_r <= {sh_r[6:0], sda};
         if (idx_r == 4'h9) first_r <= 1'h0;
         if (idx_r == 4'h9) dtx_r <= ~sda_d_oe_n;
         else if (idx_r != 4'h8 && !sda_d_oe_n) dtx_r <= 1'h1;
      end
   end

   default clocking cb @(posedge mclk_i);
   endclocking
   default disable iff (srst_i);

   dev_hold_a: assert property (
      scl && scl_r |-> $stable(sda_d_oe_n))
      else $error("device data moved while scl high");
   dev_low_a: assert property (
      !sda_d_oe_n |-> !sda_d_o)
      else $error("device drove a high level");
   // The device may only move its driver while the clock is low
   dev_edge_a: assert property (
      $changed(sda_d_oe_n) |-> !scl)
      else $error("device data moved outside clock low");
   ack_begin_a: assert property (
      $fell(scl) && idx_r == 4'h8 && first_r && sh_r[7:4] == SEL_TYPE
      |-> !sda_d_oe_n)
      else $error("address ack not driven at fall");
   addr_ack_a: assert property (
      scl && scl_r && idx_r == 4'h9 && first_r && sh_r[7:4] == SEL_TYPE
      |-> !sda_d_oe_n)
      else $error("address not acknowledged");
   addr_quiet_a: assert property (
      scl && scl_r && first_r && idx_r != 4'h9 |-> sda_d_oe_n)
      else $error("device drove during address bits");
   ack_free_a: assert property (
      scl && scl_r && idx_r == 4'h9 && dtx_r |-> sda_d_oe_n)
      else $error("device held line in master ack slot");
   stop_free_a: assert property (
      stop_w |-> sda_d_oe_n && sda_m_oe_n)
      else $error("line driven at stop");
   stop_idle_a: assert property (
      stop_w |=> sda_d_oe_n [*8])
      else $error("device active after stop");
endmodule
`default_nettype wire

// ---- tb/serial_eeprom_read_path_bench.sv ----
`timescale 1ns/1ps
`default_nettype none
module serial_eeprom_read_path_bench import sre_pkg::*;;
   logic              mclk_i = 1'h0;
   // Raised at time zero so the link-side flops see a real reset edge
   logic              srst_i = 1'h0;
   logic              ce_i = 1'h1;
   logic              jit = 1'h0;
   logic              load_en_i = 1'h0;
   logic [ADDR_W-1:0] load_addr_i = 11'h000;
   logic [DATA_W-1:0] load_data_i = 8'h00;
   logic              cmd_valid_i = 1'h0;
   logic              cmd_random_i = 1'h0;
   logic [ADDR_W-1:0] cmd_addr_i = 11'h000;
   logic [CNT_W-1:0]  cmd_count_i = 8'h00;
   logic              cmd_ready_o;
   logic              rvalid_o;
   logic              done_o;
   logic              nack_o;
   logic              byte_sent_o;
   logic [DATA_W-1:0] rdata_o;
   logic [DATA_W-1:0] mem [MEM_DEPTH];
   logic [DATA_W-1:0] wb = 8'h00;
   int                seed = 60;
   int                dcnt = 0;
   int                bcnt = 0;
   int                n_sent = 0;
   int                n_errors = 0;
   int                total_checks = 0;
   int                i;

   sre_link_if lnk ();

   sre_master #(.QTR_CYC_P(4)) sre_master_i (
      .mclk_i       (mclk_i),
      .srst_i       (srst_i),
      .ce_i         (ce_i),
      .cmd_valid_i  (cmd_valid_i),
      .cmd_ready_o  (cmd_ready_o),
      .cmd_random_i (cmd_random_i),
      .cmd_addr_i   (cmd_addr_i),
      .cmd_count_i  (cmd_count_i),
      .rdata_o      (rdata_o),
      .rvalid_o     (rvalid_o),
      .done_o       (done_o),
      .nack_o       (nack_o),
      .link         (lnk)
   );

   sre_device sre_device_i (
      .mclk_i       (mclk_i),
      .srst_i       (srst_i),
      .ce_i         (ce_i),
      .load_en_i    (load_en_i),
      .load_addr_i  (load_addr_i),
      .load_data_i  (load_data_i),
      .byte_sent_o  (byte_sent_o),
      .link         (lnk)
   );

   sre_link_monitor sre_link_monitor_i (
      .mclk_i       (mclk_i),
      .srst_i       (srst_i),
      .scl          (lnk.scl),
      .sda          (lnk.sda),
      .sda_d_o      (lnk.sda_d_o),
      .sda_d_oe_n   (lnk.sda_d_oe_n),
      .sda_m_oe_n   (lnk.sda_m_oe_n)
   );

   // Clock at 125 MHz
   always #4 mclk_i = ~mclk_i;

   // Random enable stalls freeze the master mid-frame when jitter is on
   always @(posedge mclk_i) begin
      ce_i <= jit ? (($random(seed) & 7) != 0) : 1'h1;
   end

   // Fetch count seen on the system side
   always @(posedge mclk_i) begin
      if (byte_sent_o === 1'h1) n_sent++;
   end

   // Own framing of the wire, so bit order is judged apart from both ends
   always @(negedge lnk.sda) begin
      if (lnk.scl === 1'h1) bcnt = 0;
   end
   always @(posedge lnk.scl) begin
      if (bcnt < 8) wb = {wb[6:0], lnk.sda};
      bcnt = (bcnt == 8) ? 0 : bcnt + 1;
   end

   task automatic close_out;
      $display("checks %0d errors %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      total_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // Skip a pulse still high from a frozen cycle, then wait for the next
   task automatic wpulse(input logic sel);
      int t;
      t = 0;
      while ((sel ? done_o : rvalid_o) === 1'h1) @(negedge mclk_i);
      do begin
         @(negedge mclk_i);
         t++;
      end while ((sel ? done_o : rvalid_o) !== 1'h1 && t < 4000);
      if (t >= 4000) n_errors++;
   endtask

   // One read command; the model counter follows every byte
   task automatic rd(input logic rnd, input int a, input int c);
      int   n;
      int   k;
      int   bs0;
      logic r;
      n = (c == 0) ? 1 : c;
      if (rnd) dcnt = a;
      bs0 = n_sent;
      @(posedge mclk_i);
      cmd_valid_i <= 1'h1;
      cmd_random_i <= rnd;
      cmd_addr_i <= a[10:0];
      cmd_count_i <= c[7:0];
      r = 1'h0;
      while (!r) begin
         @(negedge mclk_i);
         r = (cmd_ready_o === 1'h1);
         @(posedge mclk_i);
      end
      cmd_valid_i <= 1'h0;
      for (k = 0; k < n; k++) begin
         wpulse(1'h0);
         check(16'(rdata_o), 16'(mem[dcnt]));
         check(16'(wb), 16'(mem[dcnt]));
         dcnt = (dcnt + 1) % MEM_DEPTH;
      end
      wpulse(1'h1);
      check(16'(nack_o), 16'h0000);
      if (!jit) check(16'(n_sent - bs0), 16'(n));
   endtask

   initial begin
      srst_i <= 1'h1;
      repeat (3) @(posedge mclk_i);
      srst_i <= 1'h0;
      // Preload through the system port, mirrored in the model
      for (i = 0; i < MEM_DEPTH; i++) begin
         @(posedge mclk_i);
         mem[i] = 8'($random(seed));
         load_en_i <= 1'h1;
         load_addr_i <= 11'(i);
         load_data_i <= mem[i];
      end
      @(posedge mclk_i);
      load_en_i <= 1'h0;
      rd(1'h0, 11'h000, 8'h01);
      rd(1'h1, 11'h0fe, 8'h04);
      rd(1'h0, 11'h700, 8'h03);
      rd(1'h1, 11'h7fd, 8'h05);
      rd(1'h1, 11'h123, 8'h00);
      jit = 1'h1;
      for (i = 0; i < 8; i++) begin
         rd(1'($random(seed)), $random(seed) & 'h7ff, $random(seed) & 'h7);
      end
      close_out();
   end

   // Watchdog well beyond the expected length of the sequence
   initial begin
      repeat (80000) @(posedge mclk_i);
      n_errors++;
      close_out();
   end
endmodule
`default_nettype wire
